// File: design/ppc_pkg.sv
package ppc_pkg;
   localparam int unsigned PPC_W = 8;
   typedef logic [PPC_W-1:0] ppc_byte_t;
   typedef logic [7:0] ppc_addr_t;
   // Register offsets in the special-function register space.
   localparam ppc_addr_t PPC_ADDR_P1_DATA    = 8'h90;
   localparam ppc_addr_t PPC_ADDR_P0_OTYPE   = 8'hA4;
   localparam ppc_addr_t PPC_ADDR_P1_OTYPE   = 8'hA5;
   localparam ppc_addr_t PPC_ADDR_P0_BYPASS  = 8'hD4;
   localparam ppc_addr_t PPC_ADDR_P0_ASEL    = 8'hF1;
   localparam ppc_addr_t PPC_ADDR_P1_ASEL    = 8'hF2;
   localparam ppc_addr_t PPC_ADDR_P0_DRIVE   = 8'hF9;
   // Reset values.
   localparam ppc_byte_t PPC_RST_ONES  = 8'hFF;
   localparam ppc_byte_t PPC_RST_ZEROS = 8'h00;
   // Synchroniser stage count, matching the three stages in ppc_pin_sync.
   localparam int unsigned PPC_SYNC_STAGES = 3;
endpackage : ppc_pkg

// File: design/ppc_pin_sync.sv
`timescale 1ns/1ps
`default_nettype none
// Three-stage synchroniser; output only changes when stages two and three agree.
module ppc_pin_sync
#(
   parameter int unsigned WIDTH = 8
)
(
   input  wire logic             clk,
   input  wire logic             arst_n,
   input  wire logic [WIDTH-1:0] async_in,
   output var  logic [WIDTH-1:0] sync_out
);
   logic [WIDTH-1:0] stage1;
   logic [WIDTH-1:0] stage2;
   logic [WIDTH-1:0] stage3;
   logic [WIDTH-1:0] next_sync_out;

   // A zero-width synchroniser has nothing to carry, so it is refused at elaboration.
   if (WIDTH < 1)
   begin : g_width_check
      $error("ppc_pin_sync WIDTH must be at least 1");
   end

   always_comb
   begin
      next_sync_out = sync_out;
      for (int i = 0; i < WIDTH; i++)
      begin
         if (stage2[i] == stage3[i])
         begin
            next_sync_out[i] = stage3[i];
         end
      end
   end

   always_ff @(posedge clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         stage1   <= '1;
         stage2   <= '1;
         stage3   <= '1;
         sync_out <= '1;
      end
      else
      begin
         stage1   <= async_in;
         stage2   <= stage1;
         stage3   <= stage2;
         sync_out <= next_sync_out;
      end
   end
endmodule : ppc_pin_sync
`default_nettype wire

// File: design/ppc_port_config.sv
// Operation
// - Port-0 output type ignored while its pin is analog.
// - Port-0 output type 0 gives open-drain, 1 gives push-pull.
// - Port-1 output type ignored while its pin is analog.
// - Port-1 output type 0 gives open-drain, 1 gives push-pull.
// - Port-0 bypass bit 1 makes the crossbar skip that pin.
// - Port-0 drive bit 0 selects low strength, 1 high strength.
// - Analog port-1 pin loses pullup, driver and receiver.
// - Port-1 select 0 means analog, 1 digital; reset all ones.
// - Port-0 select 0 means analog, 1 digital; gates output type.
// - Read-modify-write on port data reads the latch, not pins.
// - Management-bus data and clock pins open-drain while their bus function is active.
`timescale 1ns/1ps
`default_nettype none
module ppc_port_config
   import ppc_pkg::*;
#(
   parameter ppc_byte_t P0_SMB_PINS = 8'h00,
   parameter ppc_byte_t P1_SMB_PINS = 8'h00
)
(
   input  wire logic               clk,
   input  wire logic               arst_n,
   input  wire ppc_pkg::ppc_addr_t sfr_addr,
   input  wire ppc_pkg::ppc_byte_t sfr_wdata,
   input  wire logic               sfr_wr,
   input  wire logic               sfr_rd,
   input  wire logic               sfr_rmw,
   output var  ppc_pkg::ppc_byte_t sfr_rdata,
   input  wire ppc_pkg::ppc_byte_t p0_out_data,
   input  wire ppc_pkg::ppc_byte_t p0_smb_active,
   input  wire ppc_pkg::ppc_byte_t p1_smb_active,
   input  wire ppc_pkg::ppc_byte_t p1_pin_in,
   output var  ppc_pkg::ppc_byte_t p0_pin_out,
   output var  ppc_pkg::ppc_byte_t p0_pin_oe_n,
   output var  ppc_pkg::ppc_byte_t p0_high_drive,
   output var  ppc_pkg::ppc_byte_t p0_xbar_skip,
   output var  ppc_pkg::ppc_byte_t p1_pin_out,
   output var  ppc_pkg::ppc_byte_t p1_pin_oe_n,
   output var  ppc_pkg::ppc_byte_t p1_pullup_en,
   output var  ppc_pkg::ppc_byte_t p1_rx_en
);
   import ppc_pkg::*;

   ppc_byte_t port1_data_latch;
   ppc_byte_t port0_output_type;
   ppc_byte_t port1_output_type;
   ppc_byte_t port0_crossbar_bypass;
   ppc_byte_t port0_analog_select;
   ppc_byte_t port1_analog_select;
   ppc_byte_t port0_drive_strength;
   ppc_byte_t next_port1_data_latch;
   ppc_byte_t next_port0_output_type;
   ppc_byte_t next_port1_output_type;
   ppc_byte_t next_port0_crossbar_bypass;
   ppc_byte_t next_port0_analog_select;
   ppc_byte_t next_port1_analog_select;
   ppc_byte_t next_port0_drive_strength;
   ppc_byte_t next_sfr_rdata;
   ppc_byte_t p1_pin_sync;
   ppc_byte_t next_p0_pin_out;
   ppc_byte_t next_p0_pin_oe_n;
   ppc_byte_t next_p0_high_drive;
   ppc_byte_t next_p0_xbar_skip;
   ppc_byte_t next_p1_pin_out;
   ppc_byte_t next_p1_pin_oe_n;
   ppc_byte_t next_p1_pullup_en;
   ppc_byte_t next_p1_rx_en;

   // Open-drain drives only lows; push-pull drives both levels. Analog pins float.
   function automatic ppc_byte_t pin_oe_n(input ppc_byte_t data,
                                          input ppc_byte_t otype,
                                          input ppc_byte_t digital,
                                          input ppc_byte_t smb);
      ppc_byte_t push_pull;
      push_pull = otype & digital & ~smb;
      return ~(digital & (push_pull | ~data));
   endfunction : pin_oe_n

   ppc_pin_sync #(
      .WIDTH    (PPC_W)
   ) u_p1_sync (
      .clk      (clk),
      .arst_n   (arst_n),
      .async_in (p1_pin_in),
      .sync_out (p1_pin_sync)
   );

   always_comb
   begin
      next_port1_data_latch      = port1_data_latch;
      next_port0_output_type     = port0_output_type;
      next_port1_output_type     = port1_output_type;
      next_port0_crossbar_bypass = port0_crossbar_bypass;
      next_port0_analog_select   = port0_analog_select;
      next_port1_analog_select   = port1_analog_select;
      next_port0_drive_strength  = port0_drive_strength;
      if (sfr_wr)
      begin
         if (sfr_addr == PPC_ADDR_P1_DATA)
         begin
            next_port1_data_latch = sfr_wdata;
         end
         else if (sfr_addr == PPC_ADDR_P0_OTYPE)
         begin
            next_port0_output_type = sfr_wdata;
         end
         else if (sfr_addr == PPC_ADDR_P1_OTYPE)
         begin
            next_port1_output_type = sfr_wdata;
         end
         else if (sfr_addr == PPC_ADDR_P0_BYPASS)
         begin
            next_port0_crossbar_bypass = sfr_wdata;
         end
         else if (sfr_addr == PPC_ADDR_P0_ASEL)
         begin
            next_port0_analog_select = sfr_wdata;
         end
         else if (sfr_addr == PPC_ADDR_P1_ASEL)
         begin
            next_port1_analog_select = sfr_wdata;
         end
         else if (sfr_addr == PPC_ADDR_P0_DRIVE)
         begin
            next_port0_drive_strength = sfr_wdata;
         end
      end
   end

   // Read data is registered, so it appears one cycle after the strobe.
   always_comb
   begin
      next_sfr_rdata = sfr_rdata;
      if (sfr_rd)
      begin
         if (sfr_addr == PPC_ADDR_P1_DATA)
         begin
            if (sfr_rmw)
            begin
               next_sfr_rdata = port1_data_latch;
            end
            else
            begin
               // Analog cells have no receiver, so they read as low.
               next_sfr_rdata = p1_pin_sync & port1_analog_select;
            end
         end
         else if (sfr_addr == PPC_ADDR_P0_OTYPE)
         begin
            next_sfr_rdata = port0_output_type;
         end
         else if (sfr_addr == PPC_ADDR_P1_OTYPE)
         begin
            next_sfr_rdata = port1_output_type;
         end
         else if (sfr_addr == PPC_ADDR_P0_BYPASS)
         begin
            next_sfr_rdata = port0_crossbar_bypass;
         end
         else if (sfr_addr == PPC_ADDR_P0_ASEL)
         begin
            next_sfr_rdata = port0_analog_select;
         end
         else if (sfr_addr == PPC_ADDR_P1_ASEL)
         begin
            next_sfr_rdata = port1_analog_select;
         end
         else if (sfr_addr == PPC_ADDR_P0_DRIVE)
         begin
            next_sfr_rdata = port0_drive_strength;
         end
         else
         begin
            next_sfr_rdata = PPC_RST_ZEROS;
         end
      end
   end

   always_comb
   begin
      next_p0_pin_out    = p0_out_data & port0_analog_select;
      next_p0_pin_oe_n   = pin_oe_n(p0_out_data, port0_output_type, port0_analog_select,
                                    p0_smb_active & P0_SMB_PINS);
      next_p0_high_drive = port0_drive_strength & port0_analog_select;
      next_p0_xbar_skip  = port0_crossbar_bypass;
      next_p1_pin_out    = port1_data_latch & port1_analog_select;
      next_p1_pin_oe_n   = pin_oe_n(port1_data_latch, port1_output_type,
                                    port1_analog_select,
                                    p1_smb_active & P1_SMB_PINS);
      next_p1_pullup_en  = port1_analog_select & ~port1_output_type;
      next_p1_rx_en      = port1_analog_select;
   end

   always_ff @(posedge clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         port1_data_latch      <= PPC_RST_ONES;
         port0_output_type     <= PPC_RST_ZEROS;
         port1_output_type     <= PPC_RST_ZEROS;
         port0_crossbar_bypass <= PPC_RST_ZEROS;
         port0_analog_select   <= PPC_RST_ONES;
         port1_analog_select   <= PPC_RST_ONES;
         port0_drive_strength  <= PPC_RST_ZEROS;
         sfr_rdata             <= PPC_RST_ZEROS;
         p0_pin_out            <= PPC_RST_ZEROS;
         p0_pin_oe_n           <= PPC_RST_ONES;
         p0_high_drive         <= PPC_RST_ZEROS;
         p0_xbar_skip          <= PPC_RST_ZEROS;
         p1_pin_out            <= PPC_RST_ZEROS;
         p1_pin_oe_n           <= PPC_RST_ONES;
         p1_pullup_en          <= PPC_RST_ZEROS;
         p1_rx_en              <= PPC_RST_ZEROS;
      end
      else
      begin
         port1_data_latch      <= next_port1_data_latch;
         port0_output_type     <= next_port0_output_type;
         port1_output_type     <= next_port1_output_type;
         port0_crossbar_bypass <= next_port0_crossbar_bypass;
         port0_analog_select   <= next_port0_analog_select;
         port1_analog_select   <= next_port1_analog_select;
         port0_drive_strength  <= next_port0_drive_strength;
         sfr_rdata             <= next_sfr_rdata;
         p0_pin_out            <= next_p0_pin_out;
         p0_pin_oe_n           <= next_p0_pin_oe_n;
         p0_high_drive         <= next_p0_high_drive;
         p0_xbar_skip          <= next_p0_xbar_skip;
         p1_pin_out            <= next_p1_pin_out;
         p1_pin_oe_n           <= next_p1_pin_oe_n;
         p1_pullup_en          <= next_p1_pullup_en;
         p1_rx_en              <= next_p1_rx_en;
      end
   end
endmodule : ppc_port_config
`default_nettype wire

// File: dv/ppc_pin_model.sv
`timescale 1ns/1ps
`default_nettype none
module ppc_pin_model
   import ppc_pkg::*;
(
   input  wire logic               clk,
   input  wire ppc_pkg::ppc_byte_t pin_out,
   input  wire ppc_pkg::ppc_byte_t pin_oe_n,
   input  wire ppc_pkg::ppc_byte_t pullup_en,
   input  wire ppc_pkg::ppc_byte_t ext_val,
   input  wire ppc_pkg::ppc_byte_t ext_en,
   output var  ppc_pkg::ppc_byte_t pin_in
);
   logic flip = 1'b0;
   always @(posedge clk) flip <= ~flip;
   // An undriven pin without pullup toggles, so a stale level is never trusted.
   always_comb
   begin
      pin_in = (~pin_oe_n & pin_out) | (pin_oe_n & ext_en & ext_val)
             | (pin_oe_n & ~ext_en & (pullup_en | {8{flip}}));
   end
endmodule : ppc_pin_model
`default_nettype wire

// File: dv/ppc_port_config_monitor.sv
`timescale 1ns/1ps
`default_nettype none
module ppc_port_config_monitor
   import ppc_pkg::*;
(
   input  wire logic               clk,
   input  wire logic               arst_n,
   input  wire ppc_pkg::ppc_addr_t sfr_addr,
   input  wire ppc_pkg::ppc_byte_t sfr_wdata,
   input  wire logic               sfr_wr,
   input  wire logic               sfr_rd,
   input  wire logic               sfr_rmw,
   input  wire ppc_pkg::ppc_byte_t sfr_rdata,
   input  wire ppc_pkg::ppc_byte_t p0_pin_oe_n,
   input  wire ppc_pkg::ppc_byte_t p0_high_drive,
   input  wire ppc_pkg::ppc_byte_t p0_xbar_skip,
   input  wire ppc_pkg::ppc_byte_t p1_pin_oe_n,
   input  wire ppc_pkg::ppc_byte_t p1_pullup_en,
   input  wire ppc_pkg::ppc_byte_t p1_rx_en,
   input  wire ppc_pkg::ppc_byte_t p1_smb_active
);
   logic mapped;
   assign mapped = sfr_addr inside {PPC_ADDR_P1_DATA, PPC_ADDR_P0_OTYPE, PPC_ADDR_P1_OTYPE,
      PPC_ADDR_P0_BYPASS, PPC_ADDR_P0_ASEL, PPC_ADDR_P1_ASEL, PPC_ADDR_P0_DRIVE};
   default clocking @(posedge clk); endclocking
   default disable iff (!arst_n);
   sequence wr_then_rd;
      sfr_wr && mapped ##1 sfr_rd && !sfr_wr && sfr_addr == $past(sfr_addr)
         && (sfr_rmw || sfr_addr != PPC_ADDR_P1_DATA);
   endsequence
   chk_unmapped_read: assert property (
      sfr_rd && !mapped |=> sfr_rdata == 8'h00) else $error("unmapped read not zero");
   chk_rdata_holds: assert property (
      !sfr_rd |=> $stable(sfr_rdata)) else $error("read data moved without a read");
   chk_write_readback: assert property (
      wr_then_rd |=> sfr_rdata == $past(sfr_wdata, 2)) else $error("read back mismatch");
   chk_rx_follows: assert property (
      sfr_wr && sfr_addr == PPC_ADDR_P1_ASEL |-> ##2 p1_rx_en == $past(sfr_wdata, 2))
      else $error("receiver enable wrong");
   chk_skip_copy: assert property (
      sfr_wr && sfr_addr == PPC_ADDR_P0_BYPASS |-> ##2 p0_xbar_skip == $past(sfr_wdata, 2))
      else $error("crossbar skip wrong");
   chk_p0_analog_off: assert property (
      sfr_wr && sfr_addr == PPC_ADDR_P0_ASEL |-> ##2 &(p0_pin_oe_n | $past(sfr_wdata, 2))
      && (p0_high_drive & ~$past(sfr_wdata, 2)) == 8'h00) else $error("analog pin active");
   chk_p1_analog_off: assert property (
      &(p1_pin_oe_n | p1_rx_en) && (p1_pullup_en & ~p1_rx_en) == 8'h00)
      else $error("analog port-1 pin active");
   // A bus function may force a push-pull pin open-drain, so such pins are excused.
   chk_push_pull_drives: assert property (
      (p1_pin_oe_n & p1_rx_en & ~p1_pullup_en & ~$past(p1_smb_active)) == 8'h00)
      else $error("push-pull released");
   cover property (sfr_rd && sfr_rmw);
   cover property (sfr_rd && !mapped);
   cover property (p1_pullup_en != 8'h00 && p1_rx_en != 8'hff);
   cover property (p1_smb_active != 8'h00 && p1_rx_en != 8'h00);
endmodule : ppc_port_config_monitor
`default_nettype wire

// File: dv/testbench.sv
`timescale 1ns/1ps
`default_nettype none
module testbench;
   import ppc_pkg::*;
   logic      clk = 1'b0, arst_n = 1'b0, sfr_wr = 1'b0, sfr_rd = 1'b0, sfr_rmw = 1'b0;
   ppc_addr_t sfr_addr = 8'h00;
   ppc_byte_t sfr_wdata = 8'h00, p0_out_data = 8'h55, p0_smb_active = 8'hff;
   ppc_byte_t ext_val = 8'hff, ext_en = 8'h00, p1_smb_active = 8'h00;
   ppc_byte_t sfr_rdata, p0_pin_out, p0_pin_oe_n, p0_high_drive, p0_xbar_skip;
   ppc_byte_t p1_pin_out, p1_pin_oe_n, p1_pullup_en, p1_rx_en, p1_pin_in;
   int        failures = 0, checked = 0, cycles = 0;
   ppc_addr_t addrs[7] = '{PPC_ADDR_P1_DATA, PPC_ADDR_P0_OTYPE, PPC_ADDR_P1_OTYPE,
      PPC_ADDR_P0_BYPASS, PPC_ADDR_P0_ASEL, PPC_ADDR_P1_ASEL, PPC_ADDR_P0_DRIVE};
   ppc_byte_t rsts[7] = '{8'hff, 8'h00, 8'h00, 8'h00, 8'hff, 8'hff, 8'h00};
   always #4 clk = ~clk;
   ppc_port_config #(.P0_SMB_PINS(8'h03), .P1_SMB_PINS(8'h30)) DUT (.clk(clk), .arst_n(arst_n),
      .sfr_addr(sfr_addr), .sfr_wdata(sfr_wdata), .sfr_wr(sfr_wr), .sfr_rd(sfr_rd),
      .sfr_rmw(sfr_rmw), .sfr_rdata(sfr_rdata), .p0_out_data(p0_out_data),
      .p0_smb_active(p0_smb_active), .p1_smb_active(p1_smb_active), .p1_pin_in(p1_pin_in),
      .p0_pin_out(p0_pin_out), .p0_pin_oe_n(p0_pin_oe_n), .p0_high_drive(p0_high_drive),
      .p0_xbar_skip(p0_xbar_skip), .p1_pin_out(p1_pin_out), .p1_pin_oe_n(p1_pin_oe_n),
      .p1_pullup_en(p1_pullup_en), .p1_rx_en(p1_rx_en));
   ppc_pin_model u_pins (.clk(clk), .pin_out(p1_pin_out), .pin_oe_n(p1_pin_oe_n),
      .pullup_en(p1_pullup_en), .ext_val(ext_val), .ext_en(ext_en), .pin_in(p1_pin_in));
   task automatic chk(string what, ppc_byte_t exp, ppc_byte_t got);
      checked++;
      if (got !== exp)
      begin
         failures++;
         $display("FAIL %s expected %h seen %h", what, exp, got);
      end
   endtask : chk
   task automatic wr(ppc_addr_t a, ppc_byte_t d);
      sfr_addr = a;
      sfr_wdata = d;
      sfr_wr = 1'b1;
      sfr_rd = 1'b0;
      @(negedge clk);
   endtask : wr
   task automatic rd(ppc_addr_t a, logic m, ppc_byte_t exp);
      sfr_addr = a;
      sfr_rmw = m;
      sfr_rd = 1'b1;
      sfr_wr = 1'b0;
      @(negedge clk);
      chk("rdata", exp, sfr_rdata);
   endtask : rd
   task automatic idle(int n);
      sfr_wr = 1'b0;
      sfr_rd = 1'b0;
      repeat (n) @(negedge clk);
   endtask : idle
   task automatic close_out;
      $display("checked %0d failures %0d", checked, failures);
      if (failures == 0 && checked > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask : close_out
   always @(posedge clk)
   begin
      cycles++;
      if (cycles == 3000)
      begin
         failures++;
         close_out();
      end
   end
   initial
   begin
      repeat (6) @(negedge clk);
      arst_n = 1'b1;
      foreach (addrs[i]) rd(addrs[i], 1'b1, rsts[i]);
      rd(8'h91, 1'b0, 8'h00);
      chk("rx_en", 8'hff, p1_rx_en);
      chk("pullup", 8'hff, p1_pullup_en);
      chk("p1_oe_n", 8'hff, p1_pin_oe_n);
      $display("test reset done");
      foreach (addrs[i])
      begin
         wr(addrs[i], 8'h3c + 8'(i));
         rd(addrs[i], 1'b1, 8'h3c + 8'(i));
      end
      wr(8'h91, 8'h00);
      foreach (addrs[i]) rd(addrs[i], 1'b1, 8'h3c + 8'(i));
      $display("test registers done");
      wr(PPC_ADDR_P1_ASEL, 8'hf0);
      wr(PPC_ADDR_P1_OTYPE, 8'h3c);
      wr(PPC_ADDR_P1_DATA, 8'h5a);
      ext_en = 8'h0f;
      idle(8);
      chk("rx_en", 8'hf0, p1_rx_en);
      chk("pullup", 8'hc0, p1_pullup_en);
      chk("p1_oe_n", 8'h4f, p1_pin_oe_n);
      chk("p1_out", 8'h10, p1_pin_out & ~p1_pin_oe_n);
      rd(PPC_ADDR_P1_DATA, 1'b0, 8'h50);
      rd(PPC_ADDR_P1_DATA, 1'b1, 8'h5a);
      p1_smb_active = 8'h30;
      idle(2);
      chk("p1_oe_n", 8'h5f, p1_pin_oe_n);
      p1_smb_active = 8'h00;
      $display("test port1 done");
      wr(PPC_ADDR_P0_ASEL, 8'hf3);
      wr(PPC_ADDR_P0_OTYPE, 8'hcf);
      wr(PPC_ADDR_P0_DRIVE, 8'hff);
      wr(PPC_ADDR_P0_BYPASS, 8'had);
      idle(2);
      chk("high_drive", 8'hf3, p0_high_drive);
      chk("skip", 8'had, p0_xbar_skip);
      chk("p0_oe_n", 8'h1d, p0_pin_oe_n);
      chk("p0_out", 8'h40, p0_pin_out & ~p0_pin_oe_n);
      $display("test port0 done");
      idle(1);
      close_out();
   end
endmodule : testbench
bind ppc_port_config ppc_port_config_monitor u_mon (.clk(clk), .arst_n(arst_n),
   .sfr_addr(sfr_addr), .sfr_wdata(sfr_wdata), .sfr_wr(sfr_wr), .sfr_rd(sfr_rd),
   .sfr_rmw(sfr_rmw), .sfr_rdata(sfr_rdata), .p0_pin_oe_n(p0_pin_oe_n),
   .p0_high_drive(p0_high_drive), .p0_xbar_skip(p0_xbar_skip), .p1_pin_oe_n(p1_pin_oe_n),
   .p1_pullup_en(p1_pullup_en), .p1_rx_en(p1_rx_en), .p1_smb_active(p1_smb_active));
`default_nettype wire
